/* File: logic/dtu_core.v */
`timescale 1ns/1ps
`default_nettype none
`include "dtu_map.vh"

module dtu_fifo #(
    parameter W = 64,
    parameter DEPTH = 64,
    parameter AW = 6
) (
    input wire clk_sys,
    input wire rst,
    input wire push,
    input wire [W-1:0] push_data,
    input wire pop,
    output wire [W-1:0] head,
    output wire [AW:0] count
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_reg;
    reg [AW-1:0] rd_reg;
    reg [AW:0] count_reg;
    // Pointers wrap by width, so DEPTH must be 2**AW
    assign head = mem[rd_reg];
    assign count = count_reg;
    always @(posedge clk_sys) begin
        if (push)
            mem[wr_reg] <= push_data;
    end
    always @(posedge clk_sys) begin
        if (rst) begin
            wr_reg <= {AW{1'b0}};
            rd_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_reg <= wr_reg + 1'b1;
            if (pop)
                rd_reg <= rd_reg + 1'b1;
            case ({push, pop})
                2'b10: count_reg <= count_reg + 1'b1;
                2'b01: count_reg <= count_reg - 1'b1;
                default: count_reg <= count_reg;
            endcase
        end
    end
endmodule

module dtu_core #(
    parameter DEPTH = `DTU_BUF_DEPTH,
    parameter AW = `DTU_BUF_AW
) (
    input wire clk_sys,
    input wire rst,
    input wire unit_sel,
    input wire key_wr,
    input wire [1:0] key_sel,
    input wire [63:0] key_data,
    input wire iv_wr,
    input wire [63:0] iv_data,
    input wire op_decrypt,
    input wire op_chain,
    input wire op_triple,
    input wire op_three_key,
    input wire job_start,
    input wire [AW:0] job_words,
    input wire in_valid,
    input wire [63:0] in_data,
    output wire in_ready,
    output wire out_valid,
    output wire [63:0] out_data,
    input wire out_ready,
    input wire [`DTU_IRQ_W-1:0] irq_mask,
    input wire [`DTU_IRQ_W-1:0] irq_clear,
    output wire irq,
    output wire [`DTU_IRQ_W-1:0] irq_pending,
    output wire [`DTU_IRQ_W-1:0] irq_active,
    output wire busy,
    output wire key_loaded
);
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_PASS = 3'h1;
    localparam [2:0] S_RUN = 3'h2;
    localparam [2:0] S_END = 3'h3;
    localparam [2:0] S_EMIT = 3'h4;
    localparam [AW:0] DEPTH_C = DEPTH;
    localparam [AW:0] ONE_C = 1;
    localparam [447:0] PC1_TAB = {
        64'h3931292119110901, 64'h3a322a221a120a02,
        64'h3b332b231b130b03, 64'h3c342c243f372f27,
        64'h1f170f073e362e26, 64'h1e160e063d352d25,
        64'h1d150d051c140c04};
    localparam [383:0] PC2_TAB = {
        64'h0e110b180105031c, 64'h0f06150a17130c04,
        64'h1a0810071b140d02, 64'h29341f252f371e28,
        64'h332d21302c312738, 64'h22352e2a32241d20};
    localparam [255:0] P_TAB = {
        64'h100714151d0c1c11, 64'h010f171a05121f0a,
        64'h0208180e201b0309, 64'h130d1e06160b0419};
    localparam [2047:0] SBOX = {
        128'he4d12fb83a6c59070f74e2d1a6cb9538,
        128'h41e8d62bfc973a50fc8249175b3ea06d,
        128'hf18e6b34972dc05a3d47f28ec01a69b5,
        128'h0e7ba4d158c6932fd8a13f42b67c05e9,
        128'ha09e63f51dc7b428d70934a6285ecbf1,
        128'hd6498f30b12c5ae71ad069874fe3b52c,
        128'h7de3069a1285bc4fd8b56f03472c1ae9,
        128'ha690cb7df13e52843f06a1d8945bc72e,
        128'h2c417ab6853fd0e9eb2c47d150fa3986,
        128'h421bad78f9c5630eb8c71e2d6f09a453,
        128'hc1af92680d34e75baf427c9561de0b38,
        128'h9ef528c3704a1db6432c95fabe17608d,
        128'h4b2ef08d3c975a61d0b7491ae35c2f86,
        128'h14bdc37eaf6805926bd814a7950fe23c,
        128'hd2846fb1a93e50c71fd8a374c56b0e92,
        128'h7b419ce206adf35821e74a8dfc90356b};

    // Initial permutation, or its inverse when inv is set
    function [63:0] dtu_ip;
        input [63:0] x;
        input inv;
        integer i;
        integer s;
        begin
            dtu_ip = 64'h0;
            for (i = 0; i < 64; i = i + 1) begin
                s = ((i / 8) < 4 ? 58 : 49) + 2 * (i / 8) - 8 * (i % 8);
                if (inv)
                    dtu_ip[64 - s] = x[63 - i];
                else
                    dtu_ip[63 - i] = x[64 - s];
            end
        end
    endfunction

    // Parity bits fall away here, leaving the 56 key bits
    function [55:0] dtu_pc1;
        input [63:0] k;
        integer i;
        begin
            dtu_pc1 = 56'h0;
            for (i = 0; i < 56; i = i + 1)
                dtu_pc1[55 - i] = k[64 - PC1_TAB[447 - 8 * i -: 8]];
        end
    endfunction

    function [47:0] dtu_pc2;
        input [55:0] cd;
        integer i;
        begin
            dtu_pc2 = 48'h0;
            for (i = 0; i < 48; i = i + 1)
                dtu_pc2[47 - i] = cd[56 - PC2_TAB[383 - 8 * i -: 8]];
        end
    endfunction

    function [31:0] dtu_f;
        input [31:0] r;
        input [47:0] k;
        reg [47:0] e;
        reg [31:0] s;
        reg [5:0] six;
        integer i;
        integer idx;
        begin
            e = 48'h0;
            s = 32'h0;
            dtu_f = 32'h0;
            for (i = 0; i < 48; i = i + 1)
                e[47 - i] = r[32 - (((i / 6) * 4 + (i % 6) + 31) % 32 + 1)];
            e = e ^ k;
            for (i = 0; i < 8; i = i + 1) begin
                six = e[47 - 6 * i -: 6];
                idx = {six[5], six[0], six[4:1]};
                s[31 - 4 * i -: 4] = SBOX[2047 - 256 * i - 4 * idx -: 4];
            end
            for (i = 0; i < 32; i = i + 1)
                dtu_f[31 - i] = s[32 - P_TAB[255 - 8 * i -: 8]];
        end
    endfunction

    function [55:0] dtu_rot;
        input [55:0] cd;
        input two;
        input left;
        begin
            if (left && two)
                dtu_rot = {cd[53:28], cd[55:54], cd[25:0], cd[27:26]};
            else if (left)
                dtu_rot = {cd[54:28], cd[55], cd[26:0], cd[27]};
            else if (two)
                dtu_rot = {cd[29:28], cd[55:30], cd[1:0], cd[27:2]};
            else
                dtu_rot = {cd[28], cd[55:29], cd[0], cd[27:1]};
        end
    endfunction

    function dtu_two;
        input [3:0] n;
        begin
            dtu_two = !(n == 4'h0 || n == 4'h1 || n == 4'h8 || n == 4'hf);
        end
    endfunction

    reg [2:0] st_reg;
    reg [1:0] pass_reg;
    reg [3:0] rnd_reg;
    reg [31:0] l_reg;
    reg [31:0] r_reg;
    reg [55:0] cd_reg;
    reg [63:0] blk_reg;
    reg [63:0] ctext_reg;
    reg [63:0] iv_reg;
    reg [63:0] first_key_reg;
    reg [63:0] second_key_reg;
    reg [63:0] third_key_reg;
    reg key_ok_reg;
    reg mdec_reg;
    reg mchain_reg;
    reg mtriple_reg;
    reg m3key_reg;
    reg job_active_reg;
    reg hold_reg;
    reg [AW:0] job_left_reg;
    reg in_ready_reg;
    reg out_valid_reg;
    reg [63:0] out_data_reg;
    reg skid_valid_reg;
    reg [63:0] skid_data_reg;
    reg [`DTU_IRQ_W-1:0] pend_reg;
    reg [`DTU_IRQ_W-1:0] pend_next;
    reg [`DTU_IRQ_W-1:0] active_reg;
    reg irq_reg;
    reg [`DTU_IRQ_W-1:0] set_v;

    wire [63:0] ib_head;
    wire [AW:0] ib_count;
    wire [63:0] ob_head;
    wire [AW:0] ob_count;
    // Host strobes except irq_clear and out_ready count only inside this unit's own address window
    wire ib_push = unit_sel && in_valid && in_ready_reg;
    wire start_ok = st_reg == S_IDLE && ib_count != 0 && key_ok_reg;
    wire ob_full = ob_count == DEPTH_C;
    wire ob_push = st_reg == S_EMIT && !ob_full;
    // A held burst is released early when the buffer fills, else deadlock
    wire up_valid = ob_count != 0 && (!hold_reg || ob_full);
    wire ob_pop = up_valid && !skid_valid_reg;
    wire [AW:0] ib_after = ib_count + {{AW{1'b0}}, ib_push}
        - {{AW{1'b0}}, start_ok};
    wire idle = st_reg == S_IDLE;

    wire pass_dec = mdec_reg ^ (pass_reg == 2'h1);
    wire [3:0] sh_idx = pass_dec ? 4'h0 - rnd_reg : rnd_reg;
    wire [55:0] cd_use = (pass_dec && rnd_reg == 4'h0) ? cd_reg :
        dtu_rot(cd_reg, dtu_two(sh_idx), !pass_dec);
    wire [31:0] f_out = dtu_f(r_reg, dtu_pc2(cd_use));
    wire [63:0] res = dtu_ip({r_reg, l_reg}, 1'b1);
    wire [63:0] third_key_eff = m3key_reg ? third_key_reg :
        first_key_reg;
    wire [63:0] pass_key = !mtriple_reg ? first_key_reg :
        (pass_reg == 2'h1) ? second_key_reg :
        ((pass_reg == 2'h0) ^ mdec_reg) ? first_key_reg : third_key_eff;

    dtu_fifo #(.W(64), .DEPTH(DEPTH), .AW(AW)) u_in_buf (
        .clk_sys(clk_sys),
        .rst(rst),
        .push(ib_push),
        .push_data(in_data),
        .pop(start_ok),
        .head(ib_head),
        .count(ib_count)
    );

    dtu_fifo #(.W(64), .DEPTH(DEPTH), .AW(AW)) u_out_buf (
        .clk_sys(clk_sys),
        .rst(rst),
        .push(ob_push),
        .push_data(blk_reg),
        .pop(ob_pop),
        .head(ob_head),
        .count(ob_count)
    );

    always @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= S_IDLE;
            pass_reg <= 2'h0;
            rnd_reg <= 4'h0;
            l_reg <= 32'h0;
            r_reg <= 32'h0;
            cd_reg <= 56'h0;
            blk_reg <= 64'h0;
            ctext_reg <= 64'h0;
            iv_reg <= `DTU_IV_RESET;
            first_key_reg <= `DTU_KEY_RESET;
            second_key_reg <= `DTU_KEY_RESET;
            third_key_reg <= `DTU_KEY_RESET;
            key_ok_reg <= 1'b0;
            mdec_reg <= 1'b0;
            mchain_reg <= 1'b0;
            mtriple_reg <= 1'b0;
            m3key_reg <= 1'b0;
            job_active_reg <= 1'b0;
            hold_reg <= 1'b0;
            job_left_reg <= {(AW+1){1'b0}};
            set_v <= {`DTU_IRQ_W{1'b0}};
        end else begin
            set_v <= {`DTU_IRQ_W{1'b0}};
            // Key and chaining value are frozen while a block runs
            if (unit_sel && key_wr && idle) begin
                case (key_sel)
                    `DTU_KEY_FIRST: first_key_reg <= key_data;
                    `DTU_KEY_SECOND: second_key_reg <= key_data;
                    `DTU_KEY_THIRD: third_key_reg <= key_data;
                    default: first_key_reg <= first_key_reg;
                endcase
                if (key_sel == `DTU_KEY_FIRST)
                    key_ok_reg <= 1'b1;
            end
            if (unit_sel && iv_wr && idle)
                iv_reg <= iv_data;
            if (unit_sel && job_start && !job_active_reg &&
                job_words != 0 && job_words <= DEPTH_C) begin
                job_active_reg <= 1'b1;
                hold_reg <= 1'b1;
                job_left_reg <= job_words;
            end
            if (ib_count != 0 && !key_ok_reg)
                set_v[`DTU_SRC_NOKEY] <= 1'b1;
            case (st_reg)
                S_IDLE: begin
                    // One block in flight at a time; the next waits here
                    if (start_ok) begin
                        mdec_reg <= op_decrypt;
                        mchain_reg <= op_chain;
                        mtriple_reg <= op_triple;
                        m3key_reg <= op_three_key;
                        ctext_reg <= ib_head;
                        blk_reg <= (op_chain && !op_decrypt) ?
                            ib_head ^ iv_reg : ib_head;
                        pass_reg <= 2'h0;
                        st_reg <= S_PASS;
                    end
                end
                S_PASS: begin
                    {l_reg, r_reg} <= dtu_ip(blk_reg, 1'b0);
                    cd_reg <= dtu_pc1(pass_key);
                    rnd_reg <= 4'h0;
                    st_reg <= S_RUN;
                end
                S_RUN: begin
                    l_reg <= r_reg;
                    r_reg <= l_reg ^ f_out;
                    cd_reg <= cd_use;
                    rnd_reg <= rnd_reg + 4'h1;
                    if (rnd_reg == `DTU_ROUND_LAST)
                        st_reg <= S_END;
                end
                S_END: begin
                    if (mtriple_reg && pass_reg != `DTU_PASS_LAST) begin
                        blk_reg <= res;
                        pass_reg <= pass_reg + 2'h1;
                        st_reg <= S_PASS;
                    end else begin
                        blk_reg <= (mchain_reg && mdec_reg) ?
                            res ^ iv_reg : res;
                        if (mchain_reg)
                            iv_reg <= mdec_reg ? ctext_reg : res;
                        st_reg <= S_EMIT;
                    end
                end
                S_EMIT: begin
                    // Results enter the output buffer in arrival order
                    if (ob_push) begin
                        st_reg <= S_IDLE;
                        if (job_active_reg) begin
                            job_left_reg <= job_left_reg - ONE_C;
                            if (job_left_reg == ONE_C) begin
                                job_active_reg <= 1'b0;
                                hold_reg <= 1'b0;
                                set_v[`DTU_SRC_JOB] <= 1'b1;
                            end
                        end else begin
                            set_v[`DTU_SRC_BLOCK] <= 1'b1;
                        end
                    end
                end
                default: st_reg <= S_IDLE;
            endcase
        end
    end

    // Ready looks one cycle ahead so a full buffer never takes a word
    always @(posedge clk_sys) begin
        if (rst)
            in_ready_reg <= 1'b0;
        else
            in_ready_reg <= ib_after < DEPTH_C;
    end

    // Two-entry skid stage: a stalled receiver loses no word
    always @(posedge clk_sys) begin
        if (rst) begin
            out_valid_reg <= 1'b0;
            out_data_reg <= 64'h0;
            skid_valid_reg <= 1'b0;
            skid_data_reg <= 64'h0;
        end else if (out_valid_reg && !out_ready) begin
            if (ob_pop) begin
                skid_valid_reg <= 1'b1;
                skid_data_reg <= ob_head;
            end
        end else if (skid_valid_reg) begin
            out_valid_reg <= 1'b1;
            out_data_reg <= skid_data_reg;
            skid_valid_reg <= 1'b0;
        end else begin
            out_valid_reg <= ob_pop;
            if (ob_pop)
                out_data_reg <= ob_head;
        end
    end

    // Set wins over a clear in the same cycle
    always @* begin
        pend_next = (pend_reg & ~irq_clear) | set_v;
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            pend_reg <= {`DTU_IRQ_W{1'b0}};
            active_reg <= {`DTU_IRQ_W{1'b0}};
            irq_reg <= 1'b0;
        end else begin
            pend_reg <= pend_next;
            active_reg <= pend_reg & ~irq_mask;
            irq_reg <= |(pend_reg & ~irq_mask);
        end
    end

    assign in_ready = in_ready_reg;
    assign out_valid = out_valid_reg;
    assign out_data = out_data_reg;
    assign irq = irq_reg;
    assign irq_pending = pend_reg;
    assign irq_active = active_reg;
    assign busy = job_active_reg;
    assign key_loaded = key_ok_reg;
endmodule
`default_nettype wire

/* File: logic/dtu_map.vh */
`ifndef DTU_MAP_VH
`define DTU_MAP_VH
`define DTU_BUF_DEPTH 64
`define DTU_BUF_AW 6
`define DTU_ROUND_LAST 4'hf
`define DTU_PASS_LAST 2'h2
`define DTU_KEY_FIRST 2'h0
`define DTU_KEY_SECOND 2'h1
`define DTU_KEY_THIRD 2'h2
`define DTU_IRQ_W 3
`define DTU_SRC_BLOCK 0
`define DTU_SRC_JOB 1
`define DTU_SRC_NOKEY 2
`define DTU_IV_RESET 64'h0
`define DTU_KEY_RESET 64'h0
`endif

/* File: test/dtu_core_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dtu_map.vh"
module dtu_core_checker #(
    parameter DEPTH = 64,
    parameter AW = 6
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic unit_sel,
    input wire logic key_wr,
    input wire logic [1:0] key_sel,
    input wire logic job_start,
    input wire logic [AW:0] job_words,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic [63:0] out_data,
    input wire logic out_ready,
    input wire logic [`DTU_IRQ_W-1:0] irq_mask,
    input wire logic [`DTU_IRQ_W-1:0] irq_clear,
    input wire logic irq,
    input wire logic [`DTU_IRQ_W-1:0] irq_pending,
    input wire logic [`DTU_IRQ_W-1:0] irq_active,
    input wire logic busy,
    input wire logic key_loaded
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // Checked while rst is high, so it opts out of the default disable
    property p_rst;
        disable iff (1'b0)
        rst |=> !out_valid && !in_ready && !busy && !key_loaded &&
            !irq && irq_pending == 0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared");
    // The guard skips the edge whose past still sees pre-reset state
    property p_act;
        !$past(rst) |-> irq_active == $past(irq_pending & ~irq_mask);
    endproperty
    a_act: assert property (p_act) else $error("active bits wrong");
    property p_irq;
        irq == (|irq_active);
    endproperty
    a_irq: assert property (p_irq) else $error("irq not OR");
    property p_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_data);
    endproperty
    a_hold: assert property (p_hold) else $error("result dropped");
    property p_key;
        $rose(key_loaded) |-> $past(unit_sel && key_wr && key_sel == 2'h0);
    endproperty
    a_key: assert property (p_key) else $error("key flag no write");
    property p_stick;
        (|(irq_pending & ~irq_clear)) |=>
            (irq_pending & $past(irq_pending & ~irq_clear)) ==
            $past(irq_pending & ~irq_clear);
    endproperty
    a_stick: assert property (p_stick) else $error("pending lost");
    // Busy drops at the edge that arms the job bit, one edge before it shows
    property p_job;
        $rose(irq_pending[1]) |-> $past(busy, 2);
    endproperty
    a_job: assert property (p_job) else $error("job irq no job");
    property p_busy;
        unit_sel && job_start && !busy && job_words != 0 &&
            job_words <= DEPTH |=> busy;
    endproperty
    a_busy: assert property (p_busy) else $error("job not started");
    sequence s_take;
        unit_sel && in_valid && in_ready && key_loaded && !busy;
    endsequence
    property p_out;
        s_take |-> ##[1:80] out_valid;
    endproperty
    a_out: assert property (p_out) else $error("no result");
    c_stall: cover property (out_valid && !out_ready);
    c_full: cover property (in_valid && !in_ready);
    c_job: cover property ($rose(irq_pending[1]));
endmodule
bind dtu_core dtu_core_checker #(.DEPTH(DEPTH), .AW(AW)) chk_u (
    .clk_sys(clk_sys), .rst(rst), .unit_sel(unit_sel), .key_wr(key_wr),
    .key_sel(key_sel), .job_start(job_start), .job_words(job_words),
    .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .irq_mask(irq_mask),
    .irq_clear(irq_clear), .irq(irq), .irq_pending(irq_pending),
    .irq_active(irq_active), .busy(busy), .key_loaded(key_loaded)
);
`default_nettype wire

/* File: test/dtu_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dtu_host_model (
    input wire logic clk_sys,
    input wire logic hold,
    output logic out_ready
);
    integer seed = 32'hafaca0d2;
    // Host takes results in turn while hold is low, stalling a quarter of the time
    initial begin
        out_ready = 0;
        forever begin
            @(negedge clk_sys);
            #1;
            out_ready = !hold && (($random(seed) & 3) != 0);
        end
    end
endmodule
`default_nettype wire

/* File: test/dtu_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dtu_core_tb;
    reg clk_sys = 0, rst = 1, unit_sel = 1, key_wr = 0, iv_wr = 0;
    reg op_decrypt = 0, op_chain = 0, op_triple = 0, op_three_key = 0;
    reg job_start = 0, in_valid = 0, hold = 0;
    reg [1:0] key_sel = 0;
    reg [63:0] key_data = 0, iv_data = 0, in_data = 0, y, e, k, iv;
    reg [6:0] job_words = 0;
    reg [2:0] irq_mask = 0, irq_clear = 0;
    wire in_ready, out_valid, out_ready, irq, busy, key_loaded;
    wire [63:0] out_data;
    wire [2:0] irq_pending, irq_active;
    integer seed = 32'hafaca0d2, errors = 0, n_tests = 0, i, j, t, acc;
    reg [63:0] rq[$], p[0:63], v[0:63], c[0:63], r[0:255];
    dtu_core dut_u (
        .clk_sys(clk_sys), .rst(rst), .unit_sel(unit_sel),
        .key_wr(key_wr), .key_sel(key_sel), .key_data(key_data),
        .iv_wr(iv_wr), .iv_data(iv_data), .op_decrypt(op_decrypt),
        .op_chain(op_chain), .op_triple(op_triple),
        .op_three_key(op_three_key), .job_start(job_start),
        .job_words(job_words), .in_valid(in_valid), .in_data(in_data),
        .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
        .out_ready(out_ready), .irq_mask(irq_mask),
        .irq_clear(irq_clear), .irq(irq), .irq_pending(irq_pending),
        .irq_active(irq_active), .busy(busy), .key_loaded(key_loaded)
    );
    dtu_host_model host_u (
        .clk_sys(clk_sys), .hold(hold), .out_ready(out_ready)
    );
    initial forever #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
        if (out_valid === 1'b1 && out_ready) rq.push_back(out_data);
    task chk(input string nm, input [63:0] s, input [63:0] x);
        begin
            n_tests = n_tests + 1;
            if (s !== x) begin
                errors = errors + 1;
                $display("MISMATCH %0s exp %h seen %h", nm, x, s);
            end
        end
    endtask
    task finish_test;
        begin
            if (errors == 0 && n_tests > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task wr(input m, input [1:0] s, input [63:0] d);
        begin
            key_sel = s;
            key_data = d;
            iv_data = d;
            key_wr = !m;
            iv_wr = m;
            @(negedge clk_sys);
            key_wr = 0;
            iv_wr = 0;
            @(negedge clk_sys);
        end
    endtask
    // Valid stays up across words; a word not taken in lim cycles ends it
    task send(input integer n, input integer lim);
        begin
            acc = 0;
            for (i = 0; i < n && acc == i; i = i + 1) begin
                in_valid = 1;
                in_data = v[i % 64];
                t = 0;
                // Ready is a registered level, settled at the falling edge
                while (in_ready !== 1'b1 && t < lim) begin
                    t = t + 1;
                    @(negedge clk_sys);
                end
                if (in_ready === 1'b1) acc = acc + 1;
                @(negedge clk_sys);
            end
            in_valid = 0;
            @(negedge clk_sys);
        end
    endtask
    task drain(input integer n);
        begin
            t = 0;
            while (rq.size() < n && t < 9000) begin
                t = t + 1;
                @(negedge clk_sys);
            end
            chk("count", rq.size(), n);
            for (i = 0; i < n; i = i + 1) r[i] = rq.pop_front();
        end
    endtask
    task go(input integer n, input [3:0] m);
        begin
            {op_three_key, op_triple, op_chain, op_decrypt} = m;
            send(n, 3000);
            drain(n);
        end
    endtask
    task one(input [3:0] m, input [63:0] x);
        begin
            v[0] = x;
            go(1, m);
            y = r[0];
        end
    endtask
    initial begin
        repeat (6) @(negedge clk_sys);
        rst = 0;
        @(negedge clk_sys);
        wr(0, 0, 64'h133457799bbcdff1);
        one(4'h0, 64'h0123456789abcdef);
        chk("kat_enc", y, 64'h85e813540f0ab405);
        one(4'h1, y);
        chk("kat_dec", y, 64'h0123456789abcdef);
        irq_mask = 3'h7;
        repeat (3) @(negedge clk_sys);
        chk("masked", {irq, irq_pending}, 4'h1);
        irq_mask = 3'h6;
        repeat (3) @(negedge clk_sys);
        chk("irq", {irq, irq_active}, 4'h9);
        irq_clear = 3'h7;
        @(negedge clk_sys);
        irq_clear = 0;
        repeat (3) @(negedge clk_sys);
        chk("cleared", {irq, irq_pending}, 4'h0);
        for (j = 0; j < 64; j = j + 1) p[j] = {$random(seed), $random(seed)};
        k = {$random(seed), $random(seed)};
        iv = {$random(seed), $random(seed)};
        wr(0, 0, k);
        for (j = 0; j < 16; j = j + 1) v[j] = p[j];
        go(16, 4'h0);
        for (j = 0; j < 16; j = j + 1) v[j] = r[j];
        go(16, 4'h1);
        for (j = 0; j < 16; j = j + 1) chk("ecb", r[j], p[j]);
        wr(1, 0, iv);
        for (j = 0; j < 4; j = j + 1) v[j] = p[j];
        go(4, 4'h2);
        for (j = 0; j < 4; j = j + 1) c[j] = r[j];
        for (j = 0; j < 4; j = j + 1) v[j] = p[j] ^ (j ? c[j-1] : iv);
        go(4, 4'h0);
        for (j = 0; j < 4; j = j + 1) chk("cbc", c[j], r[j]);
        wr(1, 0, iv);
        for (j = 0; j < 4; j = j + 1) v[j] = c[j];
        go(4, 4'h3);
        for (j = 0; j < 4; j = j + 1) chk("cbc_d", r[j], p[j]);
        wr(0, 1, p[62]);
        wr(0, 2, p[63]);
        one(4'hc, p[0]);
        e = y;
        one(4'h0, p[0]);
        wr(0, 0, p[62]);
        one(4'h1, y);
        wr(0, 0, p[63]);
        one(4'h0, y);
        chk("tecb3", e, y);
        wr(0, 0, k);
        one(4'h4, p[0]);
        c[8] = y;
        wr(0, 2, k);
        one(4'hc, p[0]);
        chk("tecb2", c[8], y);
        wr(0, 2, p[63]);
        one(4'hd, e);
        chk("tecb_d", y, p[0]);
        wr(1, 0, iv);
        one(4'he, p[1]);
        c[9] = y;
        one(4'hc, p[1] ^ iv);
        chk("tcbc", c[9], y);
        wr(1, 0, iv);
        one(4'hf, c[9]);
        chk("tcbc_d", y, p[1]);
        irq_clear = 3'h7;
        hold = 1;
        @(negedge clk_sys);
        irq_clear = 0;
        {op_three_key, op_triple, op_chain, op_decrypt} = 0;
        job_words = 64;
        job_start = 1;
        @(negedge clk_sys);
        job_start = 0;
        for (j = 0; j < 64; j = j + 1) v[j] = p[j];
        send(64, 3000);
        chk("early", out_valid, 0);
        t = 0;
        while (busy !== 1'b0 && t < 5000) begin
            t = t + 1;
            @(negedge clk_sys);
        end
        repeat (3) @(negedge clk_sys);
        chk("job_irq", {out_valid, irq_pending}, 4'ha);
        hold = 0;
        drain(64);
        for (j = 0; j < 64; j = j + 1) c[j] = r[j];
        go(64, 4'h0);
        for (j = 0; j < 64; j = j + 1) chk("burst", c[j], r[j]);
        // Both buffers fill while the host stalls; nothing may be lost
        hold = 1;
        send(200, 100);
        chk("refused", acc < 200, 1);
        hold = 0;
        drain(acc);
        for (j = 0; j < acc; j = j + 1) chk("fill", r[j], c[j % 64]);
        // Outside the unit's window neither key writes nor data may land
        unit_sel = 0;
        wr(0, 0, 64'h0);
        in_valid = 1;
        repeat (40) @(negedge clk_sys);
        in_valid = 0;
        unit_sel = 1;
        chk("unsel", rq.size(), 0);
        one(4'h0, p[0]);
        chk("unsel_key", y, c[0]);
        rst = 1;
        repeat (2) @(negedge clk_sys);
        rst = 0;
        rq.delete();
        @(negedge clk_sys);
        send(1, 100);
        repeat (40) @(negedge clk_sys);
        chk("no_key", {key_loaded, out_valid, irq_pending}, 5'h4);
        finish_test;
    end
    initial begin
        #(25 * 40000);
        errors = errors + 1;
        finish_test;
    end
endmodule
`default_nettype wire
